// >>> logic/mmas_defs.vh
// constants for the paged management memory access block
`ifndef MMAS_DEFS_VH
`define MMAS_DEFS_VH
// access types, held per byte in the type table
`define MMAS_T_RSVD 3'h0
`define MMAS_T_RW 3'h1
`define MMAS_T_RWW 3'h2
`define MMAS_T_RO 3'h3
`define MMAS_T_WO 3'h4
`define MMAS_T_WOSC 3'h5
`define MMAS_T_COR 3'h6
`define MMAS_T_MASK 3'h7
// page map: pages 0..3 required, 4 optional, 5 vendor, 6..7 reserved
`define MMAS_PG_REQ_LAST 3'h3
`define MMAS_PG_OPT 3'h4
`define MMAS_PG_VEND 3'h5
// byte offsets inside a page
`define MMAS_OFS_ADV 4'h0
`define MMAS_OFS_MON_HI 4'h2
`define MMAS_OFS_MON_LO 4'h3
`define MMAS_OFS_CMD 4'h4
`define MMAS_OFS_HSK 4'h5
`define MMAS_OFS_FLAG 4'h8
`define MMAS_OFS_VFLAG 4'h9
`define MMAS_OFS_SUM 4'hA
`define MMAS_OFS_MASK 4'hC
`define MMAS_OFS_VMASK 4'hD
`define MMAS_OFS_RSVD 4'hF
// defaults
`define MMAS_CTRL_RST 8'h00
`define MMAS_MASK_OPT_RST 8'hFF
`define MMAS_MASK_REQ_RST 8'h00
`define MMAS_ADV_BIT_OPT 0
`define MMAS_ADV_BIT_VEND 1
// self-clearing command acted on this many cycles plus one after the write
`define MMAS_SC_DELAY 4'h3
`endif

// >>> logic/mmas_flag_bank.v
// latched flag byte with mask, clear-on-read and interrupt contribution
`timescale 1ns/1ps
`default_nettype none
module mmas_flag_bank #(
  parameter W = 8,
  parameter [7:0] MASK_RST = 8'hFF
) (
  input wire clk_sys,
  input wire resetn,
  input wire init_done,
  input wire [W-1:0] cond,
  input wire enable,
  input wire clear_rd,
  input wire mask_we,
  input wire [W-1:0] mask_wdata,
  output wire [W-1:0] flags,
  output wire [W-1:0] mask,
  output wire irq_src
);
  reg [W-1:0] flag_q;
  reg [W-1:0] mask_q;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          flag_q[i] <= 1'b0;
        end else if (enable && cond[i]) begin
          flag_q[i] <= 1'b1;
        end else if (clear_rd) begin
          flag_q[i] <= 1'b0;
        end
      end
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          mask_q[i] <= 1'b1;
        end else if (init_done) begin
          mask_q[i] <= MASK_RST[i];
        end else if (mask_we) begin
          mask_q[i] <= mask_wdata[i];
        end
      end
    end
  endgenerate
  assign flags = flag_q;
  assign mask = mask_q;
  assign irq_src = |(flag_q & ~mask_q);
endmodule
`default_nettype wire

// >>> logic/mmas_core.v
// paged management memory with per-byte access types
// Contract
// - reserved pages refuse all access
// - reserved bytes in pages stay accessible
// - reserved bytes initialise to zero
// - reserved contents never used nor evaluated
// - unsupported vendor pages refuse access
// - vendor interrupts silent unless host aware
// - control registers default to zero
// - optional-page masks default to one
// - multi-byte values stored big endian
// - read-write returns last host write
// - module may also update shared bytes
// - writes to read-only bytes ignored
// - write-only reads complete, value meaningless
// - self-clearing bytes read zero after action
// - clear-on-read byte cleared after read
// - clear may merge with fresh status
// - persisting condition sets flag again
// - type mismatch never raises protocol error
// - all required pages implemented
// - optional pages advertised at runtime
// - required fields present with their page
// - advertised fields present only when advertised; vendor flag and mask bytes stay present when vendor bit clear
// - vendor masks default to one
// - interrupt held while unmasked flag set
// - masks reload on leaving init state
// - reading summary clears no flag
`timescale 1ns/1ps
`default_nettype none
`include "mmas_defs.vh"
module mmas_core #(
  parameter OPT_PAGE_EN = 1,
  parameter VEND_PAGE_EN = 0
) (
  input wire clk_sys,
  input wire resetn,
  input wire req,
  input wire we,
  input wire [2:0] page,
  input wire [3:0] offset,
  input wire [7:0] wdata,
  input wire init_exit,
  input wire host_vendor_aware,
  input wire [15:0] mon_value,
  input wire [7:0] cond_std,
  input wire [7:0] cond_vend,
  input wire [7:0] hsk_update,
  input wire hsk_update_en,
  output reg [7:0] rdata_q,
  output reg ack_q,
  output reg nack_q,
  output reg irq_q,
  output reg [7:0] cmd_pulse_q,
  output reg module_ready_q
);
  localparam ST_INIT = 1'b0;
  localparam ST_READY = 1'b1;
  reg state_q;
  reg [7:0] rw_mem_q [0:15];
  reg [7:0] hsk_q;
  reg [7:0] cmd_q;
  reg [3:0] sc_cnt_q;
  reg [15:0] mon_q;
  reg cor_std_q;
  reg cor_vend_q;
  reg [7:0] rd_d;
  reg [2:0] typ;
  reg page_ok;
  wire [7:0] flg_std;
  wire [7:0] msk_std;
  wire [7:0] flg_vend;
  wire [7:0] msk_vend;
  wire irq_std;
  wire irq_vend;
  wire wr;
  wire rd;
  wire opt_sup;
  wire vend_sup;
  wire [7:0] adv;
  wire init_done;
  wire is_opt;
  integer k;
  assign opt_sup = (OPT_PAGE_EN != 0);
  assign vend_sup = (VEND_PAGE_EN != 0);
  assign adv = {6'h00, vend_sup, opt_sup};
  assign init_done = (state_q == ST_INIT) && init_exit;
  assign is_opt = (page == `MMAS_PG_OPT);
  // page decode
  always @* begin
    page_ok = 1'b0;
    if (page <= `MMAS_PG_REQ_LAST) begin
      page_ok = 1'b1;
    end else if (page == `MMAS_PG_OPT) begin
      page_ok = opt_sup;
    end else if (page == `MMAS_PG_VEND) begin
      page_ok = vend_sup;
    end else begin
      page_ok = 1'b0;
    end
  end
  assign wr = req && we && page_ok;
  assign rd = req && !we && page_ok;
  // byte type table within a page
  always @* begin
    case (offset)
      `MMAS_OFS_ADV: typ = `MMAS_T_RO;
      `MMAS_OFS_MON_HI: typ = `MMAS_T_RO;
      `MMAS_OFS_MON_LO: typ = `MMAS_T_RO;
      `MMAS_OFS_CMD: typ = `MMAS_T_WOSC;
      `MMAS_OFS_HSK: typ = `MMAS_T_RWW;
      `MMAS_OFS_FLAG: typ = `MMAS_T_COR;
      `MMAS_OFS_VFLAG: typ = `MMAS_T_COR;
      `MMAS_OFS_SUM: typ = `MMAS_T_RO;
      `MMAS_OFS_MASK: typ = `MMAS_T_MASK;
      `MMAS_OFS_VMASK: typ = `MMAS_T_MASK;
      `MMAS_OFS_RSVD: typ = `MMAS_T_RSVD;
      default: typ = `MMAS_T_RW;
    endcase
  end
  // read mux
  always @* begin
    rd_d = 8'h00;
    case (offset)
      `MMAS_OFS_ADV: rd_d = adv;
      `MMAS_OFS_MON_HI: rd_d = mon_q[15:8];
      `MMAS_OFS_MON_LO: rd_d = mon_q[7:0];
      `MMAS_OFS_CMD: rd_d = cmd_q;
      `MMAS_OFS_HSK: rd_d = hsk_q;
      `MMAS_OFS_FLAG: rd_d = flg_std;
      `MMAS_OFS_VFLAG: rd_d = flg_vend;
      `MMAS_OFS_SUM: rd_d = {6'h00, |flg_vend, |flg_std};
      `MMAS_OFS_MASK: rd_d = is_opt ? msk_vend : msk_std;
      `MMAS_OFS_VMASK: rd_d = msk_vend;
      `MMAS_OFS_RSVD: rd_d = rw_mem_q[offset];
      default: rd_d = rw_mem_q[offset];
    endcase
  end
  // module state and answer
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_INIT;
      module_ready_q <= 1'b0;
      rdata_q <= 8'h00;
      ack_q <= 1'b0;
      nack_q <= 1'b0;
      irq_q <= 1'b0;
      mon_q <= 16'h0000;
    end else begin
      if (init_done) begin
        state_q <= ST_READY;
        module_ready_q <= 1'b1;
      end
      ack_q <= req && page_ok;
      nack_q <= req && !page_ok;
      rdata_q <= rd ? rd_d : 8'h00;
      irq_q <= irq_std || (irq_vend && host_vendor_aware);
      mon_q <= mon_value;
    end
  end
  // clear-on-read strobes land the cycle after the read is answered
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cor_std_q <= 1'b0;
      cor_vend_q <= 1'b0;
    end else begin
      cor_std_q <= rd && (offset == `MMAS_OFS_FLAG);
      cor_vend_q <= rd && (offset == `MMAS_OFS_VFLAG);
    end
  end
  // plain read-write and reserved storage
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (k = 0; k < 16; k = k + 1) begin
        rw_mem_q[k] <= `MMAS_CTRL_RST;
      end
    end else if (wr && (typ == `MMAS_T_RW)) begin
      rw_mem_q[offset] <= wdata;
    end
  end
  // shared byte, host and module both write; module wins
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hsk_q <= `MMAS_CTRL_RST;
    end else if (hsk_update_en) begin
      hsk_q <= hsk_update;
    end else if (wr && (typ == `MMAS_T_RWW)) begin
      hsk_q <= wdata;
    end
  end
  // self-clearing command byte
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cmd_q <= `MMAS_CTRL_RST;
      sc_cnt_q <= 4'h0;
      cmd_pulse_q <= 8'h00;
    end else begin
      cmd_pulse_q <= 8'h00;
      if (wr && (typ == `MMAS_T_WOSC)) begin
        cmd_q <= cmd_q | wdata;
        sc_cnt_q <= `MMAS_SC_DELAY;
      end else if (sc_cnt_q != 4'h0) begin
        sc_cnt_q <= sc_cnt_q - 4'h1;
      end else if (cmd_q != 8'h00) begin
        cmd_pulse_q <= cmd_q;
        cmd_q <= 8'h00;
      end
    end
  end
  mmas_flag_bank #(
    .W(8),
    .MASK_RST(`MMAS_MASK_REQ_RST)
  ) u_std (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .init_done(init_done),
    .cond(cond_std),
    .enable(state_q == ST_READY),
    .clear_rd(cor_std_q),
    .mask_we(wr && (offset == `MMAS_OFS_MASK) && !is_opt),
    .mask_wdata(wdata),
    .flags(flg_std),
    .mask(msk_std),
    .irq_src(irq_std)
  );
  // vendor sources and the optional-page mask byte share the masked-by-default bank
  mmas_flag_bank #(
    .W(8),
    .MASK_RST(`MMAS_MASK_OPT_RST)
  ) u_vend (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .init_done(init_done),
    .cond(cond_vend),
    .enable(state_q == ST_READY),
    .clear_rd(cor_vend_q),
    .mask_we(wr && ((offset == `MMAS_OFS_VMASK) || ((offset == `MMAS_OFS_MASK) && is_opt))),
    .mask_wdata(wdata),
    .flags(flg_vend),
    .mask(msk_vend),
    .irq_src(irq_vend)
  );
endmodule
`default_nettype wire

// >>> tb/mmas_core_assertions.sv
// port assertions for the management memory block
`timescale 1ns/1ps
`default_nettype none
module mmas_core_chk (
  input wire clk_sys,
  input wire resetn,
  input wire req,
  input wire we,
  input wire [2:0] page,
  input wire [3:0] offset,
  input wire [7:0] wdata,
  input wire init_exit,
  input wire host_vendor_aware,
  input wire ack_q,
  input wire nack_q,
  input wire irq_q,
  input wire [7:0] cmd_pulse_q,
  input wire module_ready_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_ans; req |=> ack_q != nack_q; endproperty
  a_ans: assert property (p_ans) else $error("no single answer");
  property p_nil; !req |=> !ack_q && !nack_q; endproperty
  a_nil: assert property (p_nil) else $error("answer without request");
  property p_rsv; req && page[2:1] == 2'h3 |=> nack_q; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved page answered");
  property p_vnd; req && page == 3'h5 |=> nack_q; endproperty
  a_vnd: assert property (p_vnd) else $error("vendor page answered");
  property p_req; req && page < 3'h5 |=> ack_q; endproperty
  a_req: assert property (p_req) else $error("implemented page refused");
  property p_cmd;
    req && we && page < 3'h5 && offset == 4'h4 && wdata != 8'h00 |-> ##[2:8] cmd_pulse_q != 8'h00;
  endproperty
  a_cmd: assert property (p_cmd) else $error("command not acted on");
  property p_irq;
    $fell(irq_q) |-> $past(req) || $past(req, 2) || $past(req, 3) || $past(init_exit)
      || $past(host_vendor_aware);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt dropped by itself");
  property p_ini; !module_ready_q |-> !irq_q; endproperty
  a_ini: assert property (p_ini) else $error("interrupt during init");
  property p_rdy; init_exit && !module_ready_q |=> module_ready_q; endproperty
  a_rdy: assert property (p_rdy) else $error("ready state not entered");
  c_nack: cover property (nack_q);
  c_irq: cover property (irq_q);
  c_cmd: cover property (cmd_pulse_q != 8'h00);
endmodule
`default_nettype wire

// >>> tb/mmas_host.sv
// host model issuing single byte accesses
`timescale 1ns/1ps
`default_nettype none
module mmas_host (
  input wire clk_sys,
  input wire ack_q,
  input wire nack_q,
  input wire [7:0] rdata_q,
  output logic req,
  output logic we,
  output logic [2:0] page,
  output logic [3:0] offset,
  output logic [7:0] wdata
);
  initial begin
    req = 1'b0;
    we = 1'b0;
    page = 3'h0;
    offset = 4'h0;
    wdata = 8'h00;
  end
  // one pulse request; answer sampled in the cycle after it is taken
  task automatic acc(input logic w, input logic [2:0] p, input logic [3:0] o,
    input logic [7:0] d, output logic [1:0] a, output logic [7:0] r);
    @(negedge clk_sys);
    req = 1'b1;
    we = w;
    page = p;
    offset = o;
    wdata = d;
    @(negedge clk_sys);
    a = {ack_q, nack_q};
    r = rdata_q;
    req = 1'b0;
    wdata = ~d;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the management memory block
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, s) begin n_checks++; if ((s) !== (e)) begin n_errors++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module tb;
  localparam logic [1:0] A = 2'h2, N = 2'h1;
  logic clk_sys, resetn, req, we, init_exit, aw, hsk_en, ack_q, nack_q, irq_q, rdy;
  logic [2:0] page;
  logic [3:0] offset;
  logic [7:0] wdata, cs, cv, hsk, rdata_q, cmd_q;
  logic [15:0] mon;
  int n_errors = 0, n_checks = 0;
  mmas_host host (.clk_sys(clk_sys), .ack_q(ack_q), .nack_q(nack_q), .rdata_q(rdata_q),
    .req(req), .we(we), .page(page), .offset(offset), .wdata(wdata));
  mmas_core #(.OPT_PAGE_EN(1), .VEND_PAGE_EN(0)) DUT (.clk_sys(clk_sys), .resetn(resetn),
    .req(req), .we(we), .page(page), .offset(offset), .wdata(wdata), .init_exit(init_exit),
    .host_vendor_aware(aw), .mon_value(mon), .cond_std(cs), .cond_vend(cv),
    .hsk_update(hsk), .hsk_update_en(hsk_en), .rdata_q(rdata_q), .ack_q(ack_q),
    .nack_q(nack_q), .irq_q(irq_q), .cmd_pulse_q(cmd_q), .module_ready_q(rdy));
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic ac(input logic w, input logic [2:0] p, input logic [3:0] o,
    input logic [7:0] d, input logic [1:0] ea, input logic [7:0] er);
    logic [1:0] a;
    logic [7:0] r;
    host.acc(w, p, o, d, a, r);
    `CK("answer", ea, a)
    if (!w && ea == A) `CK("rdata", er, r)
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic t_init;
    ac(0, 3'h0, 4'hC, 8'h00, A, 8'hFF);
    init_exit = 1'b1;
    cyc(1);
    init_exit = 1'b0;
    `CK("ready", 1'b1, rdy)
    ac(0, 3'h4, 4'hC, 8'h00, A, 8'hFF);
    ac(0, 3'h0, 4'hD, 8'h00, A, 8'hFF);
    ac(0, 3'h0, 4'hC, 8'h00, A, 8'h00);
    ac(0, 3'h3, 4'h6, 8'h00, A, 8'h00);
    ac(0, 3'h2, 4'hF, 8'h00, A, 8'h00);
  endtask
  task automatic t_map;
    for (int p = 0; p < 8; p++) ac(1, p[2:0], 4'h0, 8'hFF, p < 5 ? A : N, 8'h00);
    ac(0, 3'h0, 4'h0, 8'h00, A, 8'h01);
    ac(1, 3'h3, 4'h6, 8'hA5, A, 8'h00);
    ac(0, 3'h3, 4'h6, 8'h00, A, 8'hA5);
    ac(1, 3'h7, 4'h6, 8'h5A, N, 8'h00);
    ac(0, 3'h3, 4'h6, 8'h00, A, 8'hA5);
    mon = 16'hC3A5;
    ac(0, 3'h0, 4'h2, 8'h00, A, 8'hC3);
    ac(0, 3'h0, 4'h3, 8'h00, A, 8'hA5);
  endtask
  task automatic t_cmd;
    ac(1, 3'h0, 4'h4, 8'h81, A, 8'h00);
    for (int i = 0; i < 10 && cmd_q == 8'h00; i++) cyc(1);
    `CK("cmd", 8'h81, cmd_q)
    ac(0, 3'h0, 4'h4, 8'h00, A, 8'h00);
    hsk = 8'h3C;
    hsk_en = 1'b1;
    cyc(1);
    hsk_en = 1'b0;
    ac(0, 3'h0, 4'h5, 8'h00, A, 8'h3C);
  endtask
  task automatic t_flag;
    cs = 8'h04;
    cyc(1);
    cs = 8'h00;
    cyc(3);
    `CK("irq", 1'b1, irq_q)
    ac(0, 3'h0, 4'hA, 8'h00, A, 8'h01);
    cyc(2);
    `CK("irq", 1'b1, irq_q)
    ac(0, 3'h0, 4'h8, 8'h00, A, 8'h04);
    cyc(2);
    `CK("irq", 1'b0, irq_q)
    ac(0, 3'h0, 4'h8, 8'h00, A, 8'h00);
    cs = 8'h04;
    cyc(3);
    ac(0, 3'h0, 4'h8, 8'h00, A, 8'h04);
    ac(0, 3'h0, 4'h8, 8'h00, A, 8'h04);
    ac(1, 3'h0, 4'hC, 8'h04, A, 8'h00);
    cyc(3);
    `CK("irq", 1'b0, irq_q)
    cv = 8'h01;
    ac(1, 3'h0, 4'hD, 8'h00, A, 8'h00);
    cyc(3);
    `CK("irq", 1'b0, irq_q)
    aw = 1'b1;
    cyc(3);
    `CK("irq", 1'b1, irq_q)
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    cyc(3000);
    n_errors++;
    stop_test;
  end
  initial begin
    {resetn, init_exit, aw, hsk_en, cs, cv, hsk, mon} = '0;
    cyc(4);
    resetn = 1'b1;
    t_init;
    t_map;
    t_cmd;
    t_flag;
    stop_test;
  end
endmodule
bind mmas_core mmas_core_chk u_chk (.clk_sys(clk_sys), .resetn(resetn), .req(req), .we(we),
  .page(page), .offset(offset), .wdata(wdata), .init_exit(init_exit),
  .host_vendor_aware(host_vendor_aware), .ack_q(ack_q), .nack_q(nack_q), .irq_q(irq_q),
  .cmd_pulse_q(cmd_pulse_q), .module_ready_q(module_ready_q));
`default_nettype wire
